//--- design/acc_map.svh
// Offsets, field positions, reset values and codes of the comparator block
// Assumes inclusion by bare name from every design file that needs them
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

// ==========================================================
// Register byte offsets
`define ACC_OFF_CTRL0      8'h00
`define ACC_OFF_CTRL1      8'h04
`define ACC_OFF_CTRL2      8'h08
`define ACC_OFF_CTRL3      8'h0C
`define ACC_OFF_STATUS     8'h10
`define ACC_OFF_AMP_ROUTE  8'h14

// ==========================================================
// Control register fields
`define ACC_BIT_ENABLE     7
`define ACC_BIT_IRQ_EN     6
`define ACC_BIT_SENSE_HI   5
`define ACC_BIT_SENSE_LO   4
`define ACC_BIT_AUX        3
`define ACC_BIT_NEG_HI     2
`define ACC_CTRL_RESET     8'h00
`define ACC_CTRL_WMASK_FULL 8'hFF
`define ACC_CTRL_WMASK_NARROW 8'hF7

// ==========================================================
// Status register fields
`define ACC_STAT_FLAG_LO   4
`define ACC_STAT_OUT_LO    0

// ==========================================================
// Sensitivity codes
`define ACC_SENSE_TOGGLE   2'h0
`define ACC_SENSE_RSVD     2'h1
`define ACC_SENSE_FALL     2'h2
`define ACC_SENSE_RISE     2'h3

// ==========================================================
// Negative input selector codes
`define ACC_NEG_REF_DIV640 3'h0
`define ACC_NEG_REF_DIV320 3'h1
`define ACC_NEG_REF_DIV213 3'h2
`define ACC_NEG_REF_DIV160 3'h3
`define ACC_NEG_BANDGAP    3'h4
`define ACC_NEG_CONVERTER  3'h5
`define ACC_NEG_PIN        3'h6
`define ACC_NEG_RSVD       3'h7

// ==========================================================
// Bus answers
`define ACC_RESP_OKAY      2'h0
`define ACC_RESP_SLVERR    2'h2

`endif

//--- design/acc_pkg.sv
// Types shared by the comparator control block
// Assumes the map header for field widths only by convention
package acc_pkg;

  // ==========================================================
  // One channel's control byte, laid out as the register
  typedef struct packed {
    logic       enable;
    logic       irq_enable;
    logic [1:0] sense;
    logic       aux;
    logic [2:0] neg_sel;
  } acc_chan_cfg_type;

  // ==========================================================
  // Controls driven toward the analog cores
  typedef struct packed {
    logic [3:0]  enable;
    logic [11:0] neg_mux;
    logic [2:0]  amp_route;
    logic        clock_select;
  } acc_ana_ctrl_type;

endpackage

//--- design/acc_sync.sv
// Three-stage synchroniser with agreement filter
// Assumes asynchronous inputs from the analog comparator cores
`timescale 1ns/1ps
module acc_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] agree;

  // Change is accepted once stages two and three match
  assign agree = ~(s2_q ^ s3_q);

  // Synchroniser chain and filtered output
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s1_q     <= '0;
      s2_q     <= '0;
      s3_q     <= '0;
      sync_out <= '0;
    end else begin
      s1_q     <= async_in;
      s2_q     <= s1_q;
      s3_q     <= s2_q;
      sync_out <= (agree & s3_q) | (~agree & sync_out);
    end
  end

endmodule

//--- design/acc_chan.sv
// One comparator channel: gated output, edge detect and sticky flag
// Assumes a synchronised comparator level on the same clock
`timescale 1ns/1ps
`include "acc_map.svh"
module acc_chan (
  input  wire logic                      core_clk,
  input  wire logic                      reset,
  input  wire acc_pkg::acc_chan_cfg_type cfg,
  input  wire logic                      level_in,
  input  wire logic                      clear,
  output logic                           out_bit_q,
  output logic                           flag_q
);
  import acc_pkg::*;

  logic prev_q;
  logic rise;
  logic fall;
  logic event_hit;
  logic prev_d;
  logic out_d;
  logic flag_d;

  // Edge terms and event selection by sensitivity
  assign rise = level_in & ~prev_q;
  assign fall = ~level_in & prev_q;
  assign event_hit = cfg.enable &
      (((cfg.sense == `ACC_SENSE_TOGGLE) & (rise | fall)) |
       ((cfg.sense == `ACC_SENSE_FALL)   & fall) |
       ((cfg.sense == `ACC_SENSE_RISE)   & rise));
  // Disabled channel reads zero and tracks level silently
  assign out_d  = cfg.enable & level_in;
  assign prev_d = level_in;
  // Set wins over clear
  assign flag_d = event_hit | (flag_q & ~clear);

  // Channel state
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prev_q    <= 1'b0;
      out_bit_q <= 1'b0;
      flag_q    <= 1'b0;
    end else begin
      prev_q    <= prev_d;
      out_bit_q <= out_d;
      flag_q    <= flag_d;
    end
  end

endmodule

//--- design/acc_top.sv
// Comparator control block: registers, four channels, bus slave
// Assumes AXI4-Lite master on core_clk and async comparator core outputs
`timescale 1ns/1ps
`include "acc_map.svh"

module acc_top (
  input  wire logic                     core_clk,
  input  wire logic                     reset,
  // AXI4-Lite slave
  input  wire logic [7:0]               s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [7:0]               s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // Analog side
  input  wire logic [3:0]               cmp_raw,
  output acc_pkg::acc_ana_ctrl_type     ana_ctrl,
  // Interrupts and triggers
  output logic [3:0]                    cmp_irq,
  input  wire logic [3:0]               cmp_irq_ack,
  output logic [3:0]                    conv_trigger,
  output logic                          timer_capture_in
);
  import acc_pkg::*;

  // ==========================================================
  // Registers
  acc_chan_cfg_type ctrl_q [4];
  logic [2:0]       amp_route_q;
  logic [3:0]       cmp_level;
  logic [3:0]       out_bit;
  logic [3:0]       flag;
  logic [3:0]       flag_clear;

  // ==========================================================
  // Write channel state
  logic       have_aw_q;
  logic       have_w_q;
  logic [7:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic       w_lane0_q;
  logic       aw_hs;
  logic       w_hs;
  logic       aw_ok;
  logic       w_ok;
  logic       do_write;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic       wr_lane0;
  logic       wr_mapped;
  logic       have_aw_d;
  logic       have_w_d;
  logic       bvalid_d;

  // Handshakes and merged write request
  assign aw_hs    = s_axi_awvalid & s_axi_awready;
  assign w_hs     = s_axi_wvalid & s_axi_wready;
  assign aw_ok    = have_aw_q | aw_hs;
  assign w_ok     = have_w_q | w_hs;
  assign do_write = aw_ok & w_ok & ~s_axi_bvalid;
  assign wr_addr  = have_aw_q ? aw_addr_q : s_axi_awaddr;
  assign wr_data  = have_w_q ? w_data_q : s_axi_wdata[7:0];
  assign wr_lane0 = have_w_q ? w_lane0_q : s_axi_wstrb[0];
  assign have_aw_d = aw_ok & ~do_write;
  assign have_w_d  = w_ok & ~do_write;
  assign bvalid_d  = do_write | (s_axi_bvalid & ~s_axi_bready);

  // Write address decode
  logic [3:0] wr_ctrl_sel;
  logic       wr_status_sel;
  logic       wr_amp_sel;
  assign wr_ctrl_sel[0] = do_write & wr_lane0 & (wr_addr == `ACC_OFF_CTRL0);
  assign wr_ctrl_sel[1] = do_write & wr_lane0 & (wr_addr == `ACC_OFF_CTRL1);
  assign wr_ctrl_sel[2] = do_write & wr_lane0 & (wr_addr == `ACC_OFF_CTRL2);
  assign wr_ctrl_sel[3] = do_write & wr_lane0 & (wr_addr == `ACC_OFF_CTRL3);
  assign wr_status_sel = do_write & wr_lane0 &
                         (wr_addr == `ACC_OFF_STATUS);
  assign wr_amp_sel = do_write & wr_lane0 &
                      (wr_addr == `ACC_OFF_AMP_ROUTE);
  assign wr_mapped = (wr_addr == `ACC_OFF_CTRL0) |
                     (wr_addr == `ACC_OFF_CTRL1) |
                     (wr_addr == `ACC_OFF_CTRL2) |
                     (wr_addr == `ACC_OFF_CTRL3) |
                     (wr_addr == `ACC_OFF_STATUS) |
                     (wr_addr == `ACC_OFF_AMP_ROUTE);

  // Write-one clears from software, service acknowledge clears too
  assign flag_clear = ({4{wr_status_sel}} &
                       wr_data[`ACC_STAT_FLAG_LO +: 4]) | cmp_irq_ack;

  // Write channel sequencing
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      have_aw_q     <= 1'b0;
      have_w_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 8'h00;
      w_lane0_q     <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ACC_RESP_OKAY;
    end else begin
      have_aw_q     <= have_aw_d;
      have_w_q      <= have_w_d;
      if (aw_hs) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_data_q  <= s_axi_wdata[7:0];
        w_lane0_q <= s_axi_wstrb[0];
      end
      s_axi_awready <= ~have_aw_d & ~bvalid_d;
      s_axi_wready  <= ~have_w_d & ~bvalid_d;
      s_axi_bvalid  <= bvalid_d;
      if (do_write) begin
        s_axi_bresp <= wr_mapped ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
      end
    end
  end

  // Control and route registers; channels 2 and 3 keep bit 3 at zero
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) begin
        ctrl_q[i] <= `ACC_CTRL_RESET;
      end
      amp_route_q <= 3'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wr_ctrl_sel[i]) begin
          ctrl_q[i] <= wr_data & ((i < 2) ? `ACC_CTRL_WMASK_FULL :
                                  `ACC_CTRL_WMASK_NARROW);
        end
      end
      if (wr_amp_sel) begin
        amp_route_q <= wr_data[2:0];
      end
    end
  end

  // ==========================================================
  // Channels
  acc_sync #(
    .WIDTH (4)
  ) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .async_in (cmp_raw),
    .sync_out (cmp_level)
  );

  for (genvar g = 0; g < 4; g++) begin : g_chan
    acc_chan u_chan (
      .core_clk  (core_clk),
      .reset     (reset),
      .cfg       (ctrl_q[g]),
      .level_in  (cmp_level[g]),
      .clear     (flag_clear[g]),
      .out_bit_q (out_bit[g]),
      .flag_q    (flag[g])
    );
  end

  // ==========================================================
  // Read channel
  logic        ar_hs;
  logic        rvalid_d;
  logic [7:0]  rd_byte;
  logic        rd_mapped;
  logic [7:0]  status_word;

  assign ar_hs       = s_axi_arvalid & s_axi_arready;
  assign rvalid_d    = ar_hs | (s_axi_rvalid & ~s_axi_rready);
  assign status_word = {flag, out_bit};
  // Read select
  assign rd_mapped = (s_axi_araddr == `ACC_OFF_CTRL0) |
                     (s_axi_araddr == `ACC_OFF_CTRL1) |
                     (s_axi_araddr == `ACC_OFF_CTRL2) |
                     (s_axi_araddr == `ACC_OFF_CTRL3) |
                     (s_axi_araddr == `ACC_OFF_STATUS) |
                     (s_axi_araddr == `ACC_OFF_AMP_ROUTE);
  assign rd_byte =
      (s_axi_araddr == `ACC_OFF_CTRL0)     ? ctrl_q[0] :
      (s_axi_araddr == `ACC_OFF_CTRL1)     ? ctrl_q[1] :
      (s_axi_araddr == `ACC_OFF_CTRL2)     ? ctrl_q[2] :
      (s_axi_araddr == `ACC_OFF_CTRL3)     ? ctrl_q[3] :
      (s_axi_araddr == `ACC_OFF_STATUS)    ? status_word :
      (s_axi_araddr == `ACC_OFF_AMP_ROUTE) ? {5'h00, amp_route_q} :
      8'h00;

  // Read answer registers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `ACC_RESP_OKAY;
    end else begin
      s_axi_arready <= ~rvalid_d;
      s_axi_rvalid  <= rvalid_d;
      if (ar_hs) begin
        s_axi_rdata <= {24'h00_0000, rd_byte};
        s_axi_rresp <= rd_mapped ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
      end
    end
  end

  // ==========================================================
  // Analog controls, interrupts, triggers and capture
  acc_ana_ctrl_type ana_d;
  assign ana_d.enable = {ctrl_q[3].enable, ctrl_q[2].enable,
                         ctrl_q[1].enable, ctrl_q[0].enable};
  assign ana_d.neg_mux = {ctrl_q[3].neg_sel, ctrl_q[2].neg_sel,
                          ctrl_q[1].neg_sel, ctrl_q[0].neg_sel};
  assign ana_d.amp_route = amp_route_q;
  assign ana_d.clock_select = ctrl_q[0].aux;

  logic [3:0] irq_en;
  assign irq_en = {ctrl_q[3].irq_enable, ctrl_q[2].irq_enable,
                   ctrl_q[1].irq_enable, ctrl_q[0].irq_enable};

  // Output flops toward the analog cores, timer and converters
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ana_ctrl         <= '0;
      cmp_irq          <= 4'h0;
      conv_trigger     <= 4'h0;
      timer_capture_in <= 1'b0;
    end else begin
      ana_ctrl         <= ana_d;
      cmp_irq          <= flag & irq_en;
      conv_trigger     <= flag;
      timer_capture_in <= ctrl_q[1].aux & out_bit[1];
    end
  end

endmodule

//--- test/acc_cmp_model.sv
// Behavioural analog comparator cores with negative input selectors
// Assumes the bench drives pin levels in millivolts
`timescale 1ns/1ps
module acc_cmp_model #(
  parameter int VREF_MV = 2560,
  parameter int BG_MV   = 1100,
  parameter int DAC_MV  = 1000
) (
  input  wire acc_pkg::acc_ana_ctrl_type ana_ctrl,
  input  wire logic [3:0][11:0]          pos_mv,
  input  wire logic [11:0]               neg_pin_mv,
  output logic [3:0]                     cmp_raw
);
  import acc_pkg::*;
  // ==========================================================
  // Level picked by a selector code; reserved sits at 4095, which no 12-bit level can beat
  function automatic int neg_lvl(input logic [2:0] c, input int pin);
    case (c)
      3'h0: return VREF_MV * 100 / 640;
      3'h1: return VREF_MV * 100 / 320;
      3'h2: return VREF_MV * 100 / 213;
      3'h3: return VREF_MV * 100 / 160;
      3'h4: return BG_MV;
      3'h5: return DAC_MV;
      3'h6: return pin;
      default: return 4095;
    endcase
  endfunction
  // Cores compare even when disabled; gating is the block's job
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      cmp_raw[k] = pos_mv[k] > neg_lvl(ana_ctrl.neg_mux[3*k +: 3],
                                       int'(neg_pin_mv));
    end
  end
endmodule

//--- test/acc_top_chk.sv
// Port-level property checks for the comparator control block
// Assumes binding into acc_top; one clock domain throughout
`timescale 1ns/1ps
module acc_top_chk (
  input wire logic                      core_clk,
  input wire logic                      reset,
  input wire logic                      s_axi_awvalid,
  input wire logic                      s_axi_awready,
  input wire logic                      s_axi_wvalid,
  input wire logic                      s_axi_wready,
  input wire logic                      s_axi_bvalid,
  input wire logic [1:0]                s_axi_bresp,
  input wire logic                      s_axi_arvalid,
  input wire logic                      s_axi_arready,
  input wire logic [31:0]               s_axi_rdata,
  input wire logic                      s_axi_rvalid,
  input wire logic                      s_axi_rready,
  input wire logic [3:0]                cmp_raw,
  input wire acc_pkg::acc_ana_ctrl_type ana_ctrl,
  input wire logic [3:0]                cmp_irq,
  input wire logic [3:0]                conv_trigger,
  input wire logic                      timer_capture_in
);
  import acc_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  // ==========================================================
  // Bus answers, holds and refusals
  a_wr_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid) else $error("write not answered");
  a_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_rd_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_rd_refuse: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  a_rdata_upper: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  // ==========================================================
  // Flag, interrupt and capture relations
  a_irq_flag: assert property (
    (cmp_irq & ~conv_trigger) == 4'h0) else $error("irq without flag");
  a_trig_edge: assert property (
    $rose(conv_trigger[0]) |-> $past(cmp_raw[0], 6) != $past(cmp_raw[0], 7))
    else $error("flag without level change");
  a_trig_enable: assert property (
    $rose(conv_trigger[0]) |-> $past(ana_ctrl.enable[0]))
    else $error("flag on disabled channel");
  a_cap_source: assert property (
    $rose(timer_capture_in) |-> $past(cmp_raw[1], 6))
    else $error("capture without comparator level");
  c_trig: cover property ($rose(conv_trigger[0]));
  c_cap: cover property ($rose(timer_capture_in));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind acc_top acc_top_chk i_acc_top_chk (.core_clk, .reset, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .cmp_raw, .ana_ctrl, .cmp_irq, .conv_trigger,
  .timer_capture_in);

//--- test/analog_comparator_control_tb_top.sv
// Self-checking bench for the comparator control block
// Assumes acc_top, its checker and the core model compile before it
`timescale 1ns/1ps
`include "acc_map.svh"
module analog_comparator_control_tb_top;
  import acc_pkg::*;
  localparam logic [7:0] NEG_EXP  = 8'h41; // 600 mV beats 400 and 500
  localparam logic [3:0] RISE_EXP = 4'h9;  // Toggle and rise codes
  localparam logic [3:0] FALL_EXP = 4'h5;  // Toggle and fall codes
  logic             core_clk = 1'b0;
  logic             reset = 1'b1;
  logic [7:0]       s_axi_awaddr = 8'h0;
  logic [7:0]       s_axi_araddr = 8'h0;
  logic [31:0]      s_axi_wdata = 32'h0;
  logic [3:0]       s_axi_wstrb = 4'h0;
  logic             s_axi_awvalid = 1'b0;
  logic             s_axi_wvalid = 1'b0;
  logic             s_axi_bready = 1'b0;
  logic             s_axi_arvalid = 1'b0;
  logic             s_axi_rready = 1'b0;
  logic             s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic             s_axi_arready, s_axi_rvalid, timer_capture_in;
  logic [1:0]       s_axi_bresp, s_axi_rresp;
  logic [31:0]      s_axi_rdata, rd_q;
  logic [3:0]       cmp_raw, cmp_irq, conv_trigger;
  logic [3:0]       cmp_irq_ack = 4'h0;
  logic [3:0][11:0] pos_mv = '0;
  logic [11:0]      neg_pin_mv = 12'h1F4;
  acc_ana_ctrl_type ana_ctrl;
  int               error_cnt = 0;
  int               tests_run = 0;
  // ==========================================================
  // Block under test and its analog cores
  acc_top i_acc_top (.core_clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp_raw, .ana_ctrl,
    .cmp_irq, .cmp_irq_ack, .conv_trigger, .timer_capture_in);
  acc_cmp_model i_acc_cmp_model (.ana_ctrl, .pos_mv, .neg_pin_mv,
    .cmp_raw);
  // Clock, reset and watchdog
  always #4 core_clk = ~core_clk;
  initial begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
  end
  initial begin
    #100us;
    error_cnt++;
    end_of_test();
  end
  // ==========================================================
  // Comparison, bus cycles and verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("Error t=%0t got %h exp %h", $time, got, exp);
      error_cnt++;
    end
  endtask
  task automatic wr(input logic [7:0] a, d, input logic [1:0] er);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge core_clk);
      ta = ta | s_axi_awready;
      tw = tw | s_axi_wready;
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    do @(posedge core_clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
    // Let an edge pass so a following write never re-raises bready now
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge core_clk);
    s_axi_rready <= 1'b0;
    rd_q = s_axi_rdata;
    chk(32'(s_axi_rresp), 32'(er));
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a, `ACC_RESP_OKAY);
    chk(rd_q, e);
  endtask
  task automatic settle();
    repeat (7) @(posedge core_clk);
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (22) @(posedge core_clk);
    // Reset values, full writes, unmapped place
    for (int i = 0; i < 6; i++) rdc(8'(i * 4), 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(8'(i * 4), 8'hFF, `ACC_RESP_OKAY);
      rdc(8'(i * 4), i < 2 ? 32'hFF : 32'hF7);
    end
    wr(`ACC_OFF_AMP_ROUTE, 8'h07, `ACC_RESP_OKAY);
    rdc(`ACC_OFF_AMP_ROUTE, 32'h7);
    chk(32'(ana_ctrl), 32'hFFFFF);
    wr(8'h18, 8'h5A, `ACC_RESP_SLVERR);
    rd(8'h18, `ACC_RESP_SLVERR);
    chk(rd_q, 32'h0);
    // Channel 0 at 600 mV against every selector code
    pos_mv[0] <= 12'h258;
    for (int c = 0; c < 8; c++) begin
      wr(`ACC_OFF_CTRL0, 8'h80 | 8'(c), `ACC_RESP_OKAY);
      settle();
      rd(`ACC_OFF_STATUS, `ACC_RESP_OKAY);
      chk(32'(rd_q[0]), 32'(NEG_EXP[c]));
    end
    // Every sensitivity code on a rise then a fall
    for (int s = 0; s < 4; s++) begin
      pos_mv[0] <= 12'h0C8;
      wr(`ACC_OFF_CTRL0, 8'hC0 | 8'(s << 4), `ACC_RESP_OKAY);
      settle();
      wr(`ACC_OFF_STATUS, 8'hF0, `ACC_RESP_OKAY);
      pos_mv[0] <= 12'h258;
      settle();
      chk(32'(cmp_irq), 32'(RISE_EXP[s]));
      rdc(`ACC_OFF_STATUS, 32'h1 | 32'(RISE_EXP[s]) << 4);
      cmp_irq_ack <= 4'h1;
      @(posedge core_clk);
      cmp_irq_ack <= 4'h0;
      pos_mv[0] <= 12'h0C8;
      settle();
      rdc(`ACC_OFF_STATUS, 32'(FALL_EXP[s]) << 4);
      wr(`ACC_OFF_STATUS, 8'h00, `ACC_RESP_OKAY);
      rdc(`ACC_OFF_STATUS, 32'(FALL_EXP[s]) << 4);
      wr(`ACC_OFF_STATUS, 8'h10, `ACC_RESP_OKAY);
      rdc(`ACC_OFF_STATUS, 32'h0);
    end
    // Channel 1 toggles with capture on, interrupt masked
    wr(`ACC_OFF_CTRL1, 8'h88, `ACC_RESP_OKAY);
    pos_mv[1] <= 12'h258;
    settle();
    chk(32'(timer_capture_in), 32'h1);
    chk(32'(cmp_irq), 32'h0);
    chk(32'(conv_trigger), 32'h2);
    wr(`ACC_OFF_CTRL1, 8'h80, `ACC_RESP_OKAY);
    settle();
    chk(32'(timer_capture_in), 32'h0);
    // Channel 2 disabled: no output, no flag
    wr(`ACC_OFF_CTRL2, 8'h00, `ACC_RESP_OKAY);
    pos_mv[2] <= 12'h258;
    settle();
    rdc(`ACC_OFF_STATUS, 32'h22);
    chk(32'(ana_ctrl.enable), 32'hB);
    end_of_test();
  end
endmodule
